// ### ctrl_bank_regs.svh
`ifndef CTRL_BANK_REGS_SVH
`define CTRL_BANK_REGS_SVH

// Register addresses (word index on the control port)
`define ADDR_PARAM_SAVE_0      12'h800
`define ADDR_PARAM_SAVE_7      12'h807
`define ADDR_PIN_LEVEL         12'h808
`define ADDR_AUX_SAMPLE_0      12'h809
`define ADDR_AUX_SAMPLE_3      12'h80C
`define ADDR_CAPTURE_0         12'h81A
`define ADDR_CAPTURE_1         12'h81B
`define ADDR_CORE_CONTROL      12'h81C
`define ADDR_RSVD_81D          12'h81D
`define ADDR_SERIAL_OUT        12'h81E
`define ADDR_SERIAL_IN         12'h81F
`define ADDR_PIN_CFG_0         12'h820
`define ADDR_PIN_CFG_1         12'h821
`define ADDR_AUX_POWER         12'h822
`define ADDR_RSVD_823          12'h823
`define ADDR_AUX_ENABLE        12'h824
`define ADDR_RSVD_825          12'h825
`define ADDR_OSC_SHUTDOWN      12'h826
`define ADDR_DAC_SETUP         12'h827

// Core control field positions
`define CC_AUX_HOST_WR_BIT     8
`define CC_PIN_HOST_WR_BIT     7
`define CC_SAVE_HOST_WR_BIT    6

// Aux and power control: filter select field
`define AP_FILTER_HI           9
`define AP_FILTER_LO           8

// Field widths and masks
`define PARAM_MASK             32'h0FFFFFFF
`define PIN_MASK               16'h0FFF
`define AUX_MASK               16'h0FFF
`define CAPTURE_MASK           16'h0FFF
`define SERIAL_IN_MASK         32'h0000001F
`define SERIAL_OUT_MASK        32'h00003FFF
`define CORE_CTRL_MASK         32'h000031FF
`define AUX_POWER_MASK         32'h000003EF
`define AUX_ENABLE_MASK        32'h00008000
`define OSC_SHUTDOWN_MASK      32'h00000004
`define DAC_SETUP_MASK         32'h00000003
`define PIN_CFG_MASK           32'h00FFFFFF

// Reset values
`define RST_WORD32             32'h00000000
`define RST_WORD16             16'h0000
`define RST_WORD12             12'h000

// Aux sample placement in a 5.23 parameter word (low 12 bits cleared)
`define AUX_PARAM_SHIFT        12

`endif

// ### ctrl_bank_pkg.sv
package ctrl_bank_pkg;

    // Host control port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } host_req_s;

    // Frame-rate data coming from the DSP core and aux converter
    typedef struct packed {
        logic [7:0][27:0] param_words;
        logic [11:0]      pin_levels;
        logic [3:0][11:0] aux_raw;
        logic [1:0][15:0] capture_values;
    } frame_src_s;

    // Complete register state of the bank
    typedef struct packed {
        logic [7:0][31:0] param_save;
        logic [15:0]      pin_level;
        logic [3:0][15:0] aux_sample;
        logic [1:0][15:0] capture_setup;
        logic [1:0][15:0] capture_value;
        logic [15:0]      core_control;
        logic [15:0]      serial_out;
        logic [7:0]       serial_in;
        logic [1:0][23:0] pin_cfg;
        logic [15:0]      aux_power;
        logic [15:0]      aux_enable;
        logic [15:0]      osc_shutdown;
        logic [15:0]      dac_setup;
        logic [31:0]      rdata;
        logic             rvalid;
        logic             wb_trig_prev;
        logic             wb_start;
        logic [7:0][31:0] wb_image;
    } bank_state_s;

endpackage : ctrl_bank_pkg

// ### ctrl_bank.sv
`timescale 1ns/1ps
`include "ctrl_bank_regs.svh"

// Function
// - Parameter-save registers keep the selected parameters for writing out to the EEPROM.
// - Saved parameters are restored after reset by loading them from the EEPROM reader.
// - Eight 32-bit parameter-save registers hold 28-bit values with the top four bits zero.
// - While the core owns them, save registers reload from their parameter words each frame.
// - A write-back trigger edge of selectable polarity copies the save registers out.
// - With the save write mode bit set, save registers take host writes instead of core data.
// - With the pin write mode bit set, the host writes and reads twelve pin levels in bits 11:0.
// - While the core owns it, the pin setting register is updated once per audio frame.
// - Four aux data registers hold one aux converter channel each.
// - Aux results are 8-bit by default and 12-bit when the filter field selects filtering.
// - The core reads an aux sample as an unsigned 1.11 fraction from 0 to just under 2.0.
// - An aux sample placed in a 5.23 word has its top four and low twelve bits zero.
// - An 8-bit full-scale code of 255 maps to 0xFF0, about 1.99.
// - Aux data registers take host writes only while the aux write mode bit is set.
module ctrl_bank
(
    // Clock and reset
    input  wire logic                      I_CLK,
    input  wire logic                      I_RESETN,
    // Control port
    input  wire ctrl_bank_pkg::host_req_s  I_HOST_REQ,
    output logic [31:0]                    O_RDATA,
    output logic                           O_RVALID,
    // Frame update and internal sources
    input  wire logic                      I_FRAME_TICK,
    input  wire ctrl_bank_pkg::frame_src_s I_FRAME_SRC,
    // Self-boot restore and write-back
    input  wire logic                      I_RESTORE_VALID,
    input  wire logic [2:0]                I_RESTORE_INDEX,
    input  wire logic [27:0]               I_RESTORE_WORD,
    input  wire logic                      I_WB_TRIGGER,
    input  wire logic                      I_WB_FALLING,
    output logic                           O_WB_START,
    output logic [255:0]                   O_WB_IMAGE,
    // Values presented to the core
    output logic [11:0]                    O_PIN_LEVELS,
    output logic [127:0]                   O_AUX_PARAM,
    output logic [23:0]                    O_CAPTURE_SETUP,
    output logic [15:0]                    O_CORE_CONTROL
);

    // ************************************************************
    // State
    // ************************************************************

    ctrl_bank_pkg::bank_state_s st_reg;
    ctrl_bank_pkg::bank_state_s st_next;

    logic        save_host_mode;
    logic        pin_host_mode;
    logic        aux_host_mode;
    logic        aux_filter_on;
    logic        trig_edge;
    logic [31:0] read_mux;
    logic [11:0] aux_scaled [4];

    // Mode bits decoded from the live core control register; filter select from the live aux power register
    assign save_host_mode = st_reg.core_control[`CC_SAVE_HOST_WR_BIT];
    assign pin_host_mode  = st_reg.core_control[`CC_PIN_HOST_WR_BIT];
    assign aux_host_mode  = st_reg.core_control[`CC_AUX_HOST_WR_BIT];
    assign aux_filter_on  = |st_reg.aux_power[`AP_FILTER_HI:`AP_FILTER_LO];

    // Edge detect on the write-back trigger, polarity chosen by strap input
    assign trig_edge = I_WB_FALLING ? (st_reg.wb_trig_prev & ~I_WB_TRIGGER)
                                    : (~st_reg.wb_trig_prev & I_WB_TRIGGER);

    // ************************************************************
    // Aux sample scaling
    // ************************************************************

    // Unfiltered results are 8 bits; left-justify so code 255 lands at full scale
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1)
        begin : g_aux
            assign aux_scaled[ch] = aux_filter_on ? I_FRAME_SRC.aux_raw[ch]
                : {I_FRAME_SRC.aux_raw[ch][7:0], 4'h0};
            // 1.11 fraction placed in 5.23 word: top four and low twelve bits zero
            assign O_AUX_PARAM[ch*32 +: 32] = {4'h0, st_reg.aux_sample[ch][11:0],
                                               `RST_WORD12} & `PARAM_MASK;
        end
    endgenerate

    // ************************************************************
    // Read decode
    // ************************************************************

    // Unmapped and reserved locations read zero
    always_comb
    begin
        read_mux = `RST_WORD32;
        if (I_HOST_REQ.addr >= `ADDR_PARAM_SAVE_0 && I_HOST_REQ.addr <= `ADDR_PARAM_SAVE_7)
            read_mux = st_reg.param_save[I_HOST_REQ.addr[2:0]];
        else if (I_HOST_REQ.addr >= `ADDR_AUX_SAMPLE_0 && I_HOST_REQ.addr <= `ADDR_AUX_SAMPLE_3)
            read_mux = {16'h0000, st_reg.aux_sample[2'(I_HOST_REQ.addr - `ADDR_AUX_SAMPLE_0)]};
        else
        begin
            case (I_HOST_REQ.addr)
                // Pin levels read back whoever owns them
                `ADDR_PIN_LEVEL:    read_mux = {16'h0000, st_reg.pin_level};

                // Capture words return the last captured value, not the setup
                `ADDR_CAPTURE_0:    read_mux = {16'h0000, st_reg.capture_value[0]};
                `ADDR_CAPTURE_1:    read_mux = {16'h0000, st_reg.capture_value[1]};

                // Setup registers read back as stored, reserved bits zero
                `ADDR_CORE_CONTROL: read_mux = {16'h0000, st_reg.core_control};
                `ADDR_SERIAL_OUT:   read_mux = {16'h0000, st_reg.serial_out};
                `ADDR_SERIAL_IN:    read_mux = {24'h000000, st_reg.serial_in};
                `ADDR_PIN_CFG_0:    read_mux = {8'h00, st_reg.pin_cfg[0]};
                `ADDR_PIN_CFG_1:    read_mux = {8'h00, st_reg.pin_cfg[1]};
                `ADDR_AUX_POWER:    read_mux = {16'h0000, st_reg.aux_power};
                `ADDR_AUX_ENABLE:   read_mux = {16'h0000, st_reg.aux_enable};
                `ADDR_OSC_SHUTDOWN: read_mux = {16'h0000, st_reg.osc_shutdown};
                `ADDR_DAC_SETUP:    read_mux = {16'h0000, st_reg.dac_setup};

                // Reserved words hide anything a host may try to store there
                default:            read_mux = `RST_WORD32;
            endcase
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************

    // Frame refresh first, host writes after: a host write in the tick cycle
    // wins only where the host owns the register.
    always_comb
    begin
        st_next = st_reg;
        st_next.wb_trig_prev = I_WB_TRIGGER;
        st_next.wb_start     = 1'b0;
        st_next.rvalid       = I_HOST_REQ.rd;
        st_next.rdata        = I_HOST_REQ.rd ? read_mux : st_reg.rdata;

        // Restore path from the EEPROM boot reader
        if (I_RESTORE_VALID)
            st_next.param_save[I_RESTORE_INDEX] = {4'h0, I_RESTORE_WORD};

        // Frame-rate refresh from internal sources
        if (I_FRAME_TICK)
        begin
            if (!save_host_mode)
            begin
                for (int i = 0; i < 8; i++)
                    st_next.param_save[i] = {4'h0, I_FRAME_SRC.param_words[i]};
            end
            if (!pin_host_mode)
                st_next.pin_level = {4'h0, I_FRAME_SRC.pin_levels};
            if (!aux_host_mode)
            begin
                for (int i = 0; i < 4; i++)
                    st_next.aux_sample[i] = {4'h0, aux_scaled[i]};
            end
            for (int i = 0; i < 2; i++)
                st_next.capture_value[i] = I_FRAME_SRC.capture_values[i];
        end

        // Control port writes
        if (I_HOST_REQ.wr)
        begin
            if (I_HOST_REQ.addr >= `ADDR_PARAM_SAVE_0 && I_HOST_REQ.addr <= `ADDR_PARAM_SAVE_7)
            begin
                if (save_host_mode)
                    st_next.param_save[I_HOST_REQ.addr[2:0]] =
                        I_HOST_REQ.wdata & `PARAM_MASK;
            end
            else if (I_HOST_REQ.addr >= `ADDR_AUX_SAMPLE_0 &&
                     I_HOST_REQ.addr <= `ADDR_AUX_SAMPLE_3)
            begin
                if (aux_host_mode)
                    st_next.aux_sample[2'(I_HOST_REQ.addr - `ADDR_AUX_SAMPLE_0)] =
                        I_HOST_REQ.wdata[15:0] & `AUX_MASK;
            end
            else
            begin
                case (I_HOST_REQ.addr)
                    // Pin levels land only while the host owns them
                    `ADDR_PIN_LEVEL:
                        if (pin_host_mode)
                            st_next.pin_level = I_HOST_REQ.wdata[15:0] & `PIN_MASK;

                    // Capture setup: step index above source select; a read
                    // returns the captured value, so the setup is write-only
                    `ADDR_CAPTURE_0:
                        st_next.capture_setup[0] = I_HOST_REQ.wdata[15:0] & `CAPTURE_MASK;
                    `ADDR_CAPTURE_1:
                        st_next.capture_setup[1] = I_HOST_REQ.wdata[15:0] & `CAPTURE_MASK;

                    // Core control: reserved bits are dropped so that a read
                    // shows only the modes that really exist
                    `ADDR_CORE_CONTROL:
                        st_next.core_control = 16'(I_HOST_REQ.wdata & `CORE_CTRL_MASK);

                    // Serial port formats, kept for the port logic
                    `ADDR_SERIAL_OUT:
                        st_next.serial_out = 16'(I_HOST_REQ.wdata & `SERIAL_OUT_MASK);
                    `ADDR_SERIAL_IN:
                        st_next.serial_in = 8'(I_HOST_REQ.wdata & `SERIAL_IN_MASK);

                    // Pin function setup for the twelve pins
                    `ADDR_PIN_CFG_0:
                        st_next.pin_cfg[0] = 24'(I_HOST_REQ.wdata & `PIN_CFG_MASK);
                    `ADDR_PIN_CFG_1:
                        st_next.pin_cfg[1] = 24'(I_HOST_REQ.wdata & `PIN_CFG_MASK);

                    // Power, filter and converter enables; reserved bits stay zero
                    `ADDR_AUX_POWER:
                        st_next.aux_power = 16'(I_HOST_REQ.wdata & `AUX_POWER_MASK);
                    `ADDR_AUX_ENABLE:
                        st_next.aux_enable = 16'(I_HOST_REQ.wdata & `AUX_ENABLE_MASK);
                    `ADDR_OSC_SHUTDOWN:
                        st_next.osc_shutdown = 16'(I_HOST_REQ.wdata & `OSC_SHUTDOWN_MASK);
                    `ADDR_DAC_SETUP:
                        st_next.dac_setup = 16'(I_HOST_REQ.wdata & `DAC_SETUP_MASK);

                    // Reserved and unmapped words swallow the write
                    default:
                        st_next.core_control = st_reg.core_control;
                endcase
            end
        end

        // Snapshot for write-back: the image is frozen so the EEPROM writer
        // sees one coherent set even if frames keep refreshing the bank.
        if (trig_edge)
        begin
            st_next.wb_start = 1'b1;
            for (int i = 0; i < 8; i++)
                st_next.wb_image[i] = st_reg.param_save[i];
        end
    end

    // ************************************************************
    // State register
    // ************************************************************

    // All state resets to zero; the trigger history starts low
    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Straight from state flops
    assign O_RDATA         = st_reg.rdata;
    assign O_RVALID        = st_reg.rvalid;
    assign O_WB_START      = st_reg.wb_start;
    assign O_WB_IMAGE      = st_reg.wb_image;
    assign O_PIN_LEVELS    = st_reg.pin_level[11:0];
    assign O_CAPTURE_SETUP = {st_reg.capture_setup[1][11:0], st_reg.capture_setup[0][11:0]};
    assign O_CORE_CONTROL  = st_reg.core_control;

endmodule : ctrl_bank

// ### ctrl_bank_properties.sv
`timescale 1ns/1ps
// ************************************************************
// Port checks of the control register bank
// ************************************************************
module ctrl_bank_properties
(
    // Clock, reset and stimulus
    input wire logic                      I_CLK,
    input wire logic                      I_RESETN,
    input wire ctrl_bank_pkg::host_req_s  I_HOST_REQ,
    input wire logic                      I_FRAME_TICK,
    input wire ctrl_bank_pkg::frame_src_s I_FRAME_SRC,
    input wire logic                      I_WB_TRIGGER,
    input wire logic                      I_WB_FALLING,
    // Observed outputs
    input wire logic                      O_RVALID,
    input wire logic                      O_WB_START,
    input wire logic [255:0]              O_WB_IMAGE,
    input wire logic [11:0]               O_PIN_LEVELS,
    input wire logic [127:0]              O_AUX_PARAM,
    input wire logic [15:0]               O_CORE_CONTROL
);
    logic trig_reg;
    logic wb_edge;

    // Trigger history starts low like the bank's, so a level high at release counts
    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            trig_reg <= 1'b0;
        else
            trig_reg <= I_WB_TRIGGER;
    end

    // Edge in the selected direction
    assign wb_edge = I_WB_FALLING ? (trig_reg & ~I_WB_TRIGGER) : (~trig_reg & I_WB_TRIGGER);

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);

    // Steps of a control write and of a write-back request
    sequence s_cc_write;
        I_HOST_REQ.wr && (I_HOST_REQ.addr == 12'h81C);
    endsequence
    sequence s_wb_edge;
        wb_edge;
    endsequence

    a_rvalid_after_read: assert property (I_HOST_REQ.rd |=> O_RVALID)
        else $error("read answer missing");
    a_rvalid_has_cause: assert property (O_RVALID |-> $past(I_HOST_REQ.rd))
        else $error("read answer without request");
    a_wb_start_edge: assert property (s_wb_edge |=> O_WB_START)
        else $error("write-back edge not answered");
    a_wb_start_cause: assert property (O_WB_START |-> $past(wb_edge))
        else $error("write-back start without edge");
    a_wb_image_held: assert property (!O_WB_START |-> $stable(O_WB_IMAGE))
        else $error("write-back image moved");
    a_cc_write_lands: assert property (s_cc_write |=>
        O_CORE_CONTROL == ($past(I_HOST_REQ.wdata[15:0]) & 16'h31FF))
        else $error("core control write lost");
    a_pin_frame_reload: assert property (!O_CORE_CONTROL[7] && I_FRAME_TICK |=>
        O_PIN_LEVELS == $past(I_FRAME_SRC.pin_levels))
        else $error("pin levels not reloaded");
    a_pin_host_hold: assert property (O_CORE_CONTROL[7] && I_FRAME_TICK && !I_HOST_REQ.wr
        |=> $stable(O_PIN_LEVELS))
        else $error("pin levels overwritten in host mode");
    a_aux_word_zero: assert property ((O_AUX_PARAM & {4{32'hF0000FFF}}) == 128'h0)
        else $error("aux parameter word padding not zero");

endmodule : ctrl_bank_properties

// ### host_port_model.sv
`timescale 1ns/1ps
// ************************************************************
// Control port host model
// ************************************************************
module host_port_model
(
    // Clock and read answer
    input  wire logic                     i_clk,
    input  wire logic [31:0]              i_rdata,
    input  wire logic                     i_rvalid,
    // Request to the bank
    output ctrl_bank_pkg::host_req_s      o_req
);
    initial o_req = '0;

    // One-cycle request; when idle, address and data turn over so nothing stale looks valid
    task automatic put(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge i_clk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : put

    task automatic write(input logic [11:0] a, input logic [31:0] d);
        put(1'b1, a, d);
    endtask : write

    // A missing answer returns inverted data so it cannot pass
    task automatic read(input logic [11:0] a, output logic [31:0] d);
        put(1'b0, a, 32'h0);
        d = i_rvalid ? i_rdata : ~i_rdata;
    endtask : read

endmodule : host_port_model

// ### test_ctrl_bank.sv
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench of the control register bank
// ************************************************************
module test_ctrl_bank;
    logic                      I_CLK = 1'b0;
    logic                      I_RESETN = 1'b0;
    logic                      I_FRAME_TICK = 1'b0;
    logic                      I_RESTORE_VALID = 1'b0;
    logic [2:0]                I_RESTORE_INDEX = 3'h0;
    logic [27:0]               I_RESTORE_WORD = 28'h0;
    logic                      I_WB_TRIGGER = 1'b0;
    logic                      I_WB_FALLING = 1'b0;
    ctrl_bank_pkg::host_req_s  I_HOST_REQ;
    ctrl_bank_pkg::frame_src_s I_FRAME_SRC = '0;
    logic [31:0]               O_RDATA;
    logic                      O_RVALID;
    logic                      O_WB_START;
    logic [255:0]              O_WB_IMAGE;
    logic [11:0]               O_PIN_LEVELS;
    logic [127:0]              O_AUX_PARAM;
    logic [23:0]               O_CAPTURE_SETUP;
    int                        bad_count = 0;
    int                        n_tests = 0;
    int                        cycles = 0;
    logic [31:0]               seed = 32'h0000D283;
    logic [31:0]               e;
    logic [31:0]               w [3];

    host_port_model host (.i_clk(I_CLK), .i_rdata(O_RDATA), .i_rvalid(O_RVALID),
        .o_req(I_HOST_REQ));
    ctrl_bank dut (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_HOST_REQ(I_HOST_REQ),
        .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_FRAME_TICK(I_FRAME_TICK),
        .I_FRAME_SRC(I_FRAME_SRC), .I_RESTORE_VALID(I_RESTORE_VALID),
        .I_RESTORE_INDEX(I_RESTORE_INDEX), .I_RESTORE_WORD(I_RESTORE_WORD),
        .I_WB_TRIGGER(I_WB_TRIGGER), .I_WB_FALLING(I_WB_FALLING), .O_WB_START(O_WB_START),
        .O_WB_IMAGE(O_WB_IMAGE), .O_PIN_LEVELS(O_PIN_LEVELS), .O_AUX_PARAM(O_AUX_PARAM),
        .O_CAPTURE_SETUP(O_CAPTURE_SETUP), .O_CORE_CONTROL());

    // Clock and a hang limit far above the few hundred cycles needed
    always #5 I_CLK = ~I_CLK;
    always @(posedge I_CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            results();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // 8-bit mode keeps the low byte of the raw value, moved to the top of the 12-bit field
    function automatic logic [31:0] aux_exp(input logic [11:0] r, input int f);
        return (f != 0) ? {20'h0, r} : {20'h0, r[7:0], 4'h0};
    endfunction : aux_exp

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic rd_chk(input int a, input logic [31:0] exp);
        logic [31:0] got;
        host.read(a[11:0], got);
        check(got, exp);
    endtask : rd_chk

    task automatic new_src();
        logic [319:0] big;
        for (int i = 0; i < 10; i++)
            big = {big[287:0], rnd()};
        I_FRAME_SRC = big[315:0];
    endtask : new_src

    task automatic tick();
        @(negedge I_CLK) I_FRAME_TICK = 1'b1;
        @(negedge I_CLK) I_FRAME_TICK = 1'b0;
    endtask : tick

    // Moves the trigger and looks for a start pulse over three cycles
    task automatic wb(input logic lvl, input logic exp);
        logic seen;
        seen = 1'b0;
        @(negedge I_CLK) I_WB_TRIGGER = lvl;
        repeat (3) @(negedge I_CLK) seen |= O_WB_START;
        check({31'h0, seen}, {31'h0, exp});
    endtask : wb

    task automatic image_chk();
        for (int i = 0; i < 8; i++)
            check(O_WB_IMAGE[32*i +: 32], {4'h0, I_FRAME_SRC.param_words[i]});
    endtask : image_chk

    task automatic results();
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // Main sequence
    initial
    begin
        repeat (8) @(posedge I_CLK);
        @(negedge I_CLK) I_RESETN = 1'b1;
        for (int a = 32'h800; a < 32'h828; a++)
            rd_chk(a, 32'h0);
        new_src();
        tick();
        for (int a = 32'h803; a < 32'h80B; a += 5)
            host.write(a[11:0], rnd());
        for (int i = 0; i < 8; i++)
            rd_chk(32'h800 + i, {4'h0, I_FRAME_SRC.param_words[i]});
        rd_chk(32'h808, {20'h0, I_FRAME_SRC.pin_levels});
        check({20'h0, O_PIN_LEVELS}, {20'h0, I_FRAME_SRC.pin_levels});
        wb(1'b1, 1'b1);
        image_chk();
        I_WB_FALLING = 1'b1;
        new_src();
        tick();
        wb(1'b0, 1'b1);
        image_chk();
        wb(1'b1, 1'b0);
        for (int f = 0; f < 4; f++)
        begin
            host.write(12'h822, f << 8);
            new_src();
            I_FRAME_SRC.aux_raw[0] = (f == 0) ? 12'h0FF : 12'hFFF;
            tick();
            for (int i = 0; i < 4; i++)
            begin
                e = aux_exp(I_FRAME_SRC.aux_raw[i], f);
                rd_chk(32'h809 + i, e);
                check(O_AUX_PARAM[32*i +: 32], {4'h0, e[11:0], 12'h0});
            end
        end
        host.write(12'h81C, 32'hFFFF0FC0);
        rd_chk(32'h81C, 32'h01C0);
        for (int i = 0; i < 3; i++)
            w[i] = rnd();
        host.write(12'h803, w[0]);
        host.write(12'h808, w[1]);
        host.write(12'h80A, w[2]);
        new_src();
        tick();
        rd_chk(32'h803, w[0] & 32'h0FFFFFFF);
        rd_chk(32'h808, w[1] & 32'h00000FFF);
        rd_chk(32'h80A, w[2] & 32'h00000FFF);
        @(negedge I_CLK);
        {I_RESTORE_VALID, I_RESTORE_INDEX, I_RESTORE_WORD} = {1'b1, 3'h5, w[0][27:0]};
        @(negedge I_CLK) I_RESTORE_VALID = 1'b0;
        rd_chk(32'h805, {4'h0, w[0][27:0]});
        host.write(12'h81A, {20'h0, w[1][9:0], 2'h3});
        check({20'h0, O_CAPTURE_SETUP[11:0]}, {20'h0, w[1][9:0], 2'h3});
        host.write(12'h81D, w[2]);
        rd_chk(32'h81D, 32'h0);
        host.write(12'h822, 32'hFFFFFFFF);
        rd_chk(32'h822, 32'h03EF);
        results();
    end
endmodule : test_ctrl_bank

bind ctrl_bank ctrl_bank_properties chk
(
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_HOST_REQ(I_HOST_REQ),
    .I_FRAME_TICK(I_FRAME_TICK), .I_FRAME_SRC(I_FRAME_SRC), .I_WB_TRIGGER(I_WB_TRIGGER),
    .I_WB_FALLING(I_WB_FALLING), .O_RVALID(O_RVALID), .O_WB_START(O_WB_START),
    .O_WB_IMAGE(O_WB_IMAGE), .O_PIN_LEVELS(O_PIN_LEVELS), .O_AUX_PARAM(O_AUX_PARAM),
    .O_CORE_CONTROL(O_CORE_CONTROL)
);
